// file: rtl/stxa_bank.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Function
// - Twelve 16-bit registers from index 0xF6A0 hold the 192 left channel status bits.
// - Twelve 16-bit registers from index 0xF6B0 hold the 192 right channel status bits.
// - Twelve 16-bit registers from index 0xF6C0 hold the 192 left user data bits.
// - Twelve 16-bit registers from index 0xF6D0 hold the 192 right user data bits.
// - Twelve 16-bit registers from index 0xF6E0 hold the 192 left validity bits.
// - Twelve 16-bit registers from index 0xF6F0 hold the 192 right validity bits.
// - Twelve 16-bit registers from index 0xF700 hold the 192 left parity bits.
// - Twelve 16-bit registers from index 0xF710 hold the 192 right parity bits.
// - Bank contents reach the transmitter only while the source select bit is zero.
// - Every bank register is read/write over all sixteen bits and resets to zero.
// - Select zero takes aux bits from the bank, select one copies them from the receiver.
module stxa_bank #(
  parameter int unsigned AW = 18
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] frame_idx,
  input wire stxa_pkg::stxa_aux_s rx_aux,
  output stxa_pkg::stxa_aux_s tx_aux,
  output logic aux_origin_select
);

  // bit 7 flags a bank hit, bits 6:0 the flat word number
  function automatic logic [7:0] bank_flat(input logic [15:0] idx);
    logic [15:0] off;
    logic [6:0] f;
    off = idx - stxa_pkg::CS_LEFT_IDX;
    f = 7'({off[6:4], 3'b000}) + 7'({off[6:4], 2'b00}) + 7'(off[3:0]);
    return {(off < 16'(stxa_pkg::BANK_COUNT * stxa_pkg::BANK_STRIDE))
            && (off[3:0] < 4'(stxa_pkg::BANK_WORDS)), f};
  endfunction

  logic [15:0] mem [stxa_pkg::MEM_WORDS];
  logic [15:0] next_mem [stxa_pkg::MEM_WORDS];
  logic next_aux_origin_select;

  logic aw_held, next_aw_held;
  logic [AW-1:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid;
  logic [1:0] next_bresp;

  logic next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  stxa_pkg::stxa_aux_s next_tx_aux;

  logic [15:0] wr_idx, rd_idx;
  logic [7:0] wr_dec, rd_dec;
  logic wr_fire, rd_fire, wr_origin, rd_origin;
  logic [15:0] wr_merged;

  assign wr_idx = 16'(aw_addr[AW-1:2]);
  assign rd_idx = 16'(araddr[AW-1:2]);
  assign wr_dec = bank_flat(wr_idx);
  assign rd_dec = bank_flat(rd_idx);
  assign wr_origin = (wr_idx == stxa_pkg::ORIGIN_IDX);
  assign rd_origin = (rd_idx == stxa_pkg::ORIGIN_IDX);
  // a write commits once both halves are held and no response is pending
  assign wr_fire = aw_held && w_held && !bvalid;
  assign rd_fire = arvalid && arready;

  // byte lanes 2 and 3 carry nothing: registers are 16 bits wide
  always_comb
  begin
    wr_merged = wr_dec[7] ? mem[wr_dec[6:0]] : stxa_pkg::BANK_RESET;
    if (w_strb[0])
      wr_merged[7:0] = w_data[7:0];
    if (w_strb[1])
      wr_merged[15:8] = w_data[15:8];
  end

  // write address / data capture, independent order
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wr_dec[7] || wr_origin) ? stxa_pkg::RESP_OKAY : stxa_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
  end

  // register storage; unmapped writes are dropped with an error response
  always_comb
  begin
    next_mem = mem;
    next_aux_origin_select = aux_origin_select;
    if (wr_fire && wr_dec[7])
      next_mem[wr_dec[6:0]] = wr_merged;
    if (wr_fire && wr_origin && w_strb[0])
      next_aux_origin_select = w_data[stxa_pkg::ORIGIN_BIT];
  end

  // read channel: one outstanding read, answered the cycle after it is taken
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = stxa_pkg::RESP_OKAY;
      if (rd_dec[7])
        next_rdata = {16'h0000, mem[rd_dec[6:0]]};
      else if (rd_origin)
        next_rdata = {31'h0000_0000, aux_origin_select};
      else
        next_rresp = stxa_pkg::RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  // per-frame aux bits toward the encoder, one cycle after frame_idx
  always_comb
  begin
    next_tx_aux = '0;
    if (aux_origin_select != stxa_pkg::ORIGIN_REGS)
      next_tx_aux = rx_aux;
    else if (frame_idx < 8'(stxa_pkg::FRAME_BITS))
    begin
      for (int b = 0; b < stxa_pkg::BANK_COUNT; b++)
        next_tx_aux[b] = mem[b * stxa_pkg::BANK_WORDS + int'(frame_idx[7:4])][frame_idx[3:0]];
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < stxa_pkg::MEM_WORDS; i++)
        mem[i] <= stxa_pkg::BANK_RESET;
      aux_origin_select <= stxa_pkg::ORIGIN_RESET;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= stxa_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= stxa_pkg::RESP_OKAY;
      tx_aux <= '0;
    end
    else
    begin
      mem <= next_mem;
      aux_origin_select <= next_aux_origin_select;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      tx_aux <= next_tx_aux;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  status_left_span_a: assert property (
    rd_fire && rd_idx >= stxa_pkg::CS_LEFT_IDX && rd_idx <= 16'hF6AB |=> rvalid && rresp == stxa_pkg::RESP_OKAY)
    else $error("status left read refused");

  status_right_gap_a: assert property (
    rd_fire && rd_idx == 16'hF6BC |=> rvalid && rresp == stxa_pkg::RESP_SLVERR)
    else $error("word past right status bank answered okay");

  user_left_store_a: assert property (
    wr_fire && wr_idx >= stxa_pkg::USER_LEFT_IDX && wr_idx <= 16'hF6CB && w_strb[1:0] == 2'b11
    |=> mem[7'h18 + 7'($past(wr_idx[3:0]))] == $past(w_data[15:0]))
    else $error("user left word not stored");

  user_right_bit_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx == 8'h10 |=> tx_aux.user_right == $past(mem[37][0]))
    else $error("user right frame 16 bit wrong");

  validity_left_bit_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx == 8'hBF
    |=> tx_aux.validity_left == $past(mem[59][15]))
    else $error("validity left frame 191 bit wrong");

  validity_right_resp_a: assert property (
    wr_fire && wr_idx >= stxa_pkg::VALID_RIGHT_IDX && wr_idx <= 16'hF6FB |=> bvalid && bresp == stxa_pkg::RESP_OKAY)
    else $error("validity right write refused");

  parity_left_bit_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx == 8'h21 |=> tx_aux.parity_left == $past(mem[74][1]))
    else $error("parity left frame 33 bit wrong");

  parity_right_read_a: assert property (
    rd_fire && rd_idx == 16'hF71B |=> rdata == {16'h0000, $past(mem[95])} && rresp == stxa_pkg::RESP_OKAY)
    else $error("parity right last word read wrong");

  origin_gate_a: assert property (
    aux_origin_select != stxa_pkg::ORIGIN_REGS |=> tx_aux == $past(rx_aux))
    else $error("receiver aux bits not passed through");

  upper_zero_a: assert property (
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  frame_order_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx < 8'hC0
    |=> tx_aux.status_left == $past(mem[frame_idx[7:4]][frame_idx[3:0]]))
    else $error("status left bit order wrong");

  status_right_bit_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx == 8'h11 |=> tx_aux.status_right == $past(mem[13][1]))
    else $error("status right frame 17 bit wrong");

  user_left_bit_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx == 8'h22 |=> tx_aux.user_left == $past(mem[26][2]))
    else $error("user left frame 34 bit wrong");

  validity_right_bit_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx == 8'h55
    |=> tx_aux.validity_right == $past(mem[65][5]))
    else $error("validity right frame 85 bit wrong");

  parity_right_bit_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx == 8'hBF
    |=> tx_aux.parity_right == $past(mem[95][15]))
    else $error("parity right frame 191 bit wrong");

  bank_beyond_a: assert property (
    aux_origin_select == stxa_pkg::ORIGIN_REGS && frame_idx >= 8'hC0 |=> tx_aux == 8'h00)
    else $error("aux bits past frame 191 not zero");

  origin_write_a: assert property (
    wr_fire && wr_idx == stxa_pkg::ORIGIN_IDX && w_strb[0] |=> aux_origin_select == $past(w_data[0]))
    else $error("source select write not taken");

  origin_read_a: assert property (
    rd_fire && rd_idx == stxa_pkg::ORIGIN_IDX
    |=> rdata == {31'h0000_0000, $past(aux_origin_select)} && rresp == stxa_pkg::RESP_OKAY)
    else $error("source select read wrong");

  write_done_c: cover property (wr_fire && wr_dec[7] ##1 bvalid && bready);
  read_done_c: cover property (rd_fire && rd_dec[7] ##1 rvalid && rready);
  origin_flip_c: cover property (aux_origin_select ##1 !aux_origin_select);
  gap_error_c: cover property (bvalid && bresp == stxa_pkg::RESP_SLVERR);
  receiver_path_c: cover property (aux_origin_select && rx_aux != 8'h00);
endmodule

// file: rtl/stxa_pkg.sv
package stxa_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BANK_WORDS = 12;
  localparam int unsigned BANK_STRIDE = 16;
  localparam int unsigned BANK_COUNT = 8;
  localparam int unsigned FRAME_BITS = 192;
  localparam int unsigned MEM_WORDS = BANK_COUNT * BANK_WORDS;
  // register indices; byte address is four times the index
  localparam logic [15:0] ORIGIN_IDX = 16'hF69F;
  localparam logic [15:0] CS_LEFT_IDX = 16'hF6A0;
  localparam logic [15:0] CS_RIGHT_IDX = 16'hF6B0;
  localparam logic [15:0] USER_LEFT_IDX = 16'hF6C0;
  localparam logic [15:0] USER_RIGHT_IDX = 16'hF6D0;
  localparam logic [15:0] VALID_LEFT_IDX = 16'hF6E0;
  localparam logic [15:0] VALID_RIGHT_IDX = 16'hF6F0;
  localparam logic [15:0] PARITY_LEFT_IDX = 16'hF700;
  localparam logic [15:0] PARITY_RIGHT_IDX = 16'hF710;
  localparam int unsigned ORIGIN_BIT = 0;
  localparam logic ORIGIN_RESET = 1'b0;
  localparam logic ORIGIN_REGS = 1'b0;
  localparam logic [15:0] BANK_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // bit n of the packed form is bank n in address order
  typedef struct packed {
    logic parity_right;
    logic parity_left;
    logic validity_right;
    logic validity_left;
    logic user_right;
    logic user_left;
    logic status_right;
    logic status_left;
  } stxa_aux_s;
endpackage

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [7:0] frame_idx = '0;
  stxa_pkg::stxa_aux_s rx_aux = '0;
  logic awready, wready, bvalid, arready, rvalid, aux_origin_select;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  stxa_pkg::stxa_aux_s tx_aux;
  logic [15:0] shadow [8][12];
  logic [7:0] exp_aux;
  int n_errors = 0;
  int checked = 0;
  // index in the top half, data in the bottom half; one row per bank
  logic [31:0] rows [8] = '{32'hF6A0_FFFF, 32'hF6B1_0002, 32'hF6C2_0004, 32'hF6D3_0008,
    32'hF6E4_0010, 32'hF6F5_0020, 32'hF70A_4000, 32'hF71B_8000};
  int frames [12] = '{0, 17, 191, 5, 36, 16, 33, 34, 51, 68, 85, 174};

  stxa_bank #(.AW(18)) i_dut (.core_clk(core_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .frame_idx(frame_idx),
    .rx_aux(rx_aux), .tx_aux(tx_aux), .aux_origin_select(aux_origin_select));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // starts one edge late so a release by the previous call never meets a new raise
  task automatic bus_write(input logic [15:0] idx, input logic [15:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge core_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    bready <= 1'b0;
    r = bresp;
    if (n == 64)
    begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic bus_read(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge core_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n == 64)
    begin
      n_errors++;
      print_verdict();
    end
  endtask

  // output is registered: frame sampled at one edge, shown after the next
  task automatic aux_check(input logic [7:0] f, input logic [7:0] exp);
    @(posedge core_clk);
    frame_idx <= f;
    repeat (2) @(posedge core_clk);
    #1;
    chk({24'h00_0000, tx_aux}, {24'h00_0000, exp}, "aux bits");
  endtask

  initial
  begin
    foreach (shadow[b, w])
      shadow[b][w] = 16'h0000;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    bus_read(16'hF6A0, rd, resp);
    chk(rd, 32'h0000_0000, "bank reset");
    bus_read(16'hF71B, rd, resp);
    chk(rd, 32'h0000_0000, "last word reset");
    bus_read(stxa_pkg::ORIGIN_IDX, rd, resp);
    chk(rd, 32'h0000_0000, "select reset");
    $display("test reset done");
    foreach (rows[i])
    begin
      bus_write(rows[i][31:16], rows[i][15:0], resp);
      chk({30'h0000_0000, resp}, {30'h0000_0000, stxa_pkg::RESP_OKAY}, "write resp");
      shadow[int'(rows[i][31:16] - 16'hF6A0) / 16][rows[i][19:16]] = rows[i][15:0];
      bus_read(rows[i][31:16], rd, resp);
      chk(rd, {16'h0000, rows[i][15:0]}, "read back");
    end
    $display("test bank rows done");
    // gap between banks must not alias onto a bank word
    bus_write(16'hF6AC, 16'h1234, resp);
    chk({30'h0000_0000, resp}, {30'h0000_0000, stxa_pkg::RESP_SLVERR}, "gap write");
    bus_read(16'hF6AC, rd, resp);
    chk({rd[29:0], resp}, {30'h0000_0000, stxa_pkg::RESP_SLVERR}, "gap read");
    bus_read(16'hF6B0, rd, resp);
    chk(rd, 32'h0000_0000, "gap no alias");
    bus_read(16'hF6BC, rd, resp);
    chk({rd[29:0], resp}, {30'h0000_0000, stxa_pkg::RESP_SLVERR}, "right gap read");
    $display("test gap done");
    // receiver pattern all ones so a wrong source shows
    rx_aux <= 8'hFF;
    foreach (frames[k])
    begin
      for (int n = 0; n < 8; n++)
        exp_aux[n] = shadow[n][frames[k] / 16][frames[k] % 16];
      aux_check(8'(frames[k]), exp_aux);
    end
    aux_check(8'hC0, 8'h00);
    $display("test bank source done");
    bus_write(stxa_pkg::ORIGIN_IDX, 16'h0001, resp);
    chk({30'h0000_0000, resp}, {30'h0000_0000, stxa_pkg::RESP_OKAY}, "select write resp");
    chk({31'h0000_0000, aux_origin_select}, 32'h0000_0001, "select set");
    rx_aux <= 8'h5A;
    aux_check(8'h00, 8'h5A);
    // clearing the select must hand the output back to the bank
    bus_write(stxa_pkg::ORIGIN_IDX, 16'h0000, resp);
    aux_check(8'h00, 8'h01);
    bus_write(stxa_pkg::ORIGIN_IDX, 16'h0001, resp);
    $display("test receiver source done");
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus_read(16'hF6A0, rd, resp);
    chk(rd, 32'h0000_0000, "bank after reset");
    chk({31'h0000_0000, aux_origin_select}, 32'h0000_0000, "select after reset");
    $display("test mid reset done");
    print_verdict();
  end
endmodule
